//--- hw/fixed_speed_map.svh
/*
 * Register offsets, field positions, reset values and source codes for the
 * fixed speed setpoint selector. Assumes inclusion by bare name.
 */
`ifndef FIXED_SPEED_MAP_SVH
`define FIXED_SPEED_MAP_SVH

// byte offsets, one word each
`define FSS_OFS_VALUE_BASE 12'h000
`define FSS_OFS_METHOD 12'h040
`define FSS_OFS_SRC_BASE 12'h050
`define FSS_OFS_EFFECTIVE 12'h060
`define FSS_OFS_STATE 12'h064
`define FSS_OFS_INVERT 12'h068
`define FSS_OFS_MAIN_SRC 12'h06C
`define FSS_OFS_SETPOINT 12'h070

`define FSS_METHOD_DIRECT 8'h01
`define FSS_METHOD_BINARY 8'h02
`define FSS_METHOD_RESET 8'h01
`define FSS_VALUE_RESET 32'h00000000
`define FSS_SRC_RESET 32'h00000000
`define FSS_INVERT_RESET 32'h00000000
`define FSS_MAIN_SRC_RESET 32'h00000000

// signal source codes: [15:8] group, [7:0] bit index
`define FSS_SRC_GRP_CONST 8'h00
`define FSS_SRC_GRP_DIN 8'h01
`define FSS_SRC_GRP_CTRL 8'h02
`define FSS_CTRL_INVERT_BIT 4'hB

// main setpoint source codes
`define FSS_MAIN_EXTERNAL 32'h00000000
`define FSS_MAIN_FIXED 32'h00000001

`define FSS_STATE_SEL_BIT 0

`endif

//--- hw/fixed_speed_pkg.sv
/*
 * Types for the fixed speed setpoint selector.
 * Assumes the map header for numeric constants.
 */
package fixed_speed_pkg;
    typedef enum logic [1:0] {
        AHB_IDLE_ST = 2'b00,
        AHB_WRITE_ST = 2'b01
    } ahb_state_t;
    typedef logic [31:0] speed_t;
endpackage

//--- hw/bit_source_if.sv
/*
 * Carrier between the selector top and its bit source muxes.
 * Assumes one clock domain; pure combinational payload.
 */
`timescale 1ns/100ps
interface bit_source_if #(parameter int DIN_W = 8);
    logic [31:0] code;
    logic [DIN_W-1:0] din;
    logic [15:0] ctrl_word;
    logic bit_out;
    modport mux (input code, input din, input ctrl_word, output bit_out);
    modport user (output code, output din, output ctrl_word, input bit_out);
endinterface // bit_source_if

//--- hw/bit_source_mux.sv
/*
 * Routes one binary signal picked by a source code: constant, digital input
 * or control word bit. Assumes inputs already synchronised.
 */
`timescale 1ns/100ps
`include "fixed_speed_map.svh"
module bit_source_mux
    import fixed_speed_pkg::*;
#(
    parameter int DIN_W = 8
) (
    bit_source_if.mux src
);
    logic [7:0] grp;
    logic [7:0] idx;
    assign grp = src.code[15:8];
    assign idx = src.code[7:0];

    always_comb begin
        src.bit_out = 1'b0;
        unique case (grp)
            `FSS_SRC_GRP_CONST: src.bit_out = idx[0];
            `FSS_SRC_GRP_DIN: src.bit_out = (idx < 8'(DIN_W)) ? src.din[idx[$clog2(DIN_W)-1:0]] : 1'b0;
            `FSS_SRC_GRP_CTRL: src.bit_out = src.ctrl_word[idx[3:0]];
            default: src.bit_out = 1'b0;
        endcase
    end
endmodule // bit_source_mux

//--- hw/fixed_speed_select.sv
/*
 * Fixed speed setpoint selector with AHB-Lite register slave.
 * Direct summing of four values or binary indexing of fifteen, result and
 * status readback, main setpoint source select and sign inversion.
 * Assumes digital inputs and control word arrive asynchronously.
 */
// Chosen here: register access over AHB-Lite and the register addresses.
// Functional notes
// R01: direct mode sums the four stored values whose selection bits are set.
// R02: binary mode uses the four selection bits as a code picking one value.
// R03: selection method register, 1 direct, 2 binary, resets to 1.
// R04: stored values 1 to 15 are writable and reset to zero.
// R05: four selection bit sources are routable and reset to constant zero.
// R06: selection bit k drives stored value k+1 in direct mode.
// R07: the effective result is always readable and feeds the main setpoint.
// R08: the selected status bit is 1 while any fixed value is selected.
// R09: main setpoint source can be switched to the effective fixed result.
// R10: setpoint sign is negated while the inversion bit is 1.
// R11: inversion may be routed to control word bit 11 by the controller.
// R12: no bit set or code zero gives result zero and clears the status bit.
// R13: nonzero code n picks value n; output updates on the next clock edge.
`timescale 1ns/100ps
`include "fixed_speed_map.svh"
module fixed_speed_select
    import fixed_speed_pkg::*;
#(
    parameter int DIN_W = 8,
    parameter int NUM_VALUES = 15
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [DIN_W-1:0] din,
    input wire logic [15:0] ctrl_word,
    input wire logic [31:0] external_setpoint,
    output logic [31:0] effective_fixed_speed,
    output logic fixed_speed_selected_flag,
    output logic [31:0] speed_setpoint
);
    speed_t value_q [1:NUM_VALUES];
    logic [7:0] selection_method_q;
    logic [31:0] select_source_q [0:3];
    logic [31:0] invert_source_q;
    logic [31:0] main_setpoint_source_q;

    logic [DIN_W-1:0] din_meta_q;
    logic [DIN_W-1:0] din_sync_q;
    logic [15:0] ctrl_meta_q;
    logic [15:0] ctrl_sync_q;

    ahb_state_t state_q;
    logic [11:0] waddr_q;
    logic [3:0] sel_bits;
    logic invert_bit;
    speed_t fixed_d;
    logic selected_d;
    speed_t main_d;
    speed_t eff_q;
    logic flag_q;
    speed_t setp_q;
    logic [31:0] rdata_d;
    logic [31:0] hrdata_q;
    logic addr_phase;

    // pins come from outside the clock domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            din_meta_q <= '0;
            din_sync_q <= '0;
            ctrl_meta_q <= '0;
            ctrl_sync_q <= '0;
        end else begin
            din_meta_q <= din;
            din_sync_q <= din_meta_q;
            ctrl_meta_q <= ctrl_word;
            ctrl_sync_q <= ctrl_meta_q;
        end
    end

    // four selection bits and the inversion bit share one mux type
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_src
            bit_source_if #(.DIN_W(DIN_W)) sif ();
            assign sif.code = (g < 4) ? select_source_q[g % 4] : invert_source_q; // [R05] [R11]
            assign sif.din = din_sync_q;
            assign sif.ctrl_word = ctrl_sync_q;
            bit_source_mux #(.DIN_W(DIN_W)) u_mux (
                .src(sif.mux)
            );
            if (g < 4) begin : g_sel
                assign sel_bits[g] = sif.bit_out;
            end else begin : g_inv
                assign invert_bit = sif.bit_out;
            end
        end
    endgenerate

    always_comb begin
        fixed_d = '0;
        selected_d = 1'b0;
        if (selection_method_q == `FSS_METHOD_BINARY) begin
            if (sel_bits != 4'h0 && int'(sel_bits) <= NUM_VALUES) begin
                fixed_d = value_q[int'(sel_bits)]; // [R02] [R13]
            end
            selected_d = (sel_bits != 4'h0); // [R08] [R12]
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (sel_bits[k]) begin
                    fixed_d = fixed_d + value_q[k + 1]; // [R01] [R06]
                end
            end
            selected_d = |sel_bits; // [R08] [R12]
        end
    end

    always_comb begin
        main_d = (main_setpoint_source_q == `FSS_MAIN_FIXED) ? fixed_d : external_setpoint; // [R09] [R07]
        if (invert_bit) begin
            main_d = 32'(-main_d); // [R10]
        end
    end

    // registered results: one cycle after a selection change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eff_q <= '0;
            flag_q <= 1'b0;
            setp_q <= '0;
        end else begin
            eff_q <= fixed_d; // [R07] [R13]
            flag_q <= selected_d; // [R08]
            setp_q <= main_d; // [R10]
        end
    end

    assign effective_fixed_speed = eff_q;
    assign fixed_speed_selected_flag = flag_q;
    assign speed_setpoint = setp_q;

    // ahb-lite slave, zero wait states, always okay
    assign addr_phase = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= AHB_IDLE_ST;
            waddr_q <= '0;
        end else if (addr_phase && hwrite) begin
            state_q <= AHB_WRITE_ST;
            waddr_q <= haddr;
        end else if (hready) begin
            state_q <= AHB_IDLE_ST;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 1; i <= NUM_VALUES; i++) begin
                value_q[i] <= `FSS_VALUE_RESET; // [R04]
            end
        end else if (state_q == AHB_WRITE_ST) begin
            for (int i = 1; i <= NUM_VALUES; i++) begin
                if (waddr_q == 12'(`FSS_OFS_VALUE_BASE + 4 * (i - 1))) begin
                    value_q[i] <= hwdata; // [R04]
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            selection_method_q <= `FSS_METHOD_RESET; // [R03]
        end else if (state_q == AHB_WRITE_ST && waddr_q == `FSS_OFS_METHOD) begin
            selection_method_q <= hwdata[7:0]; // [R03]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                select_source_q[i] <= `FSS_SRC_RESET; // [R05]
            end
        end else if (state_q == AHB_WRITE_ST) begin
            for (int i = 0; i < 4; i++) begin
                if (waddr_q == 12'(`FSS_OFS_SRC_BASE + 4 * i)) begin
                    select_source_q[i] <= hwdata; // [R05]
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            invert_source_q <= `FSS_INVERT_RESET;
            main_setpoint_source_q <= `FSS_MAIN_SRC_RESET;
        end else if (state_q == AHB_WRITE_ST) begin
            if (waddr_q == `FSS_OFS_INVERT) begin
                invert_source_q <= hwdata; // [R10]
            end
            if (waddr_q == `FSS_OFS_MAIN_SRC) begin
                main_setpoint_source_q <= hwdata; // [R09]
            end
        end
    end

    always_comb begin
        rdata_d = '0;
        for (int i = 1; i <= NUM_VALUES; i++) begin
            if (haddr == 12'(`FSS_OFS_VALUE_BASE + 4 * (i - 1))) begin
                rdata_d = value_q[i];
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (haddr == 12'(`FSS_OFS_SRC_BASE + 4 * i)) begin
                rdata_d = select_source_q[i];
            end
        end
        if (haddr == `FSS_OFS_METHOD) begin
            rdata_d = {24'h000000, selection_method_q};
        end
        if (haddr == `FSS_OFS_EFFECTIVE) begin
            rdata_d = eff_q; // [R07]
        end
        if (haddr == `FSS_OFS_STATE) begin
            rdata_d = {31'h00000000, flag_q}; // [R08]
        end
        if (haddr == `FSS_OFS_INVERT) begin
            rdata_d = invert_source_q;
        end
        if (haddr == `FSS_OFS_MAIN_SRC) begin
            rdata_d = main_setpoint_source_q;
        end
        if (haddr == `FSS_OFS_SETPOINT) begin
            rdata_d = setp_q;
        end
    end

    // read data captured at the address phase, stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
        end else if (addr_phase && !hwrite) begin
            hrdata_q <= rdata_d;
        end
    end
endmodule // fixed_speed_select

//--- tb/fixed_speed_monitor.sv
/* checker on the selector's top ports.
   assumes one clock domain, bound from this file. */
`timescale 1ns/100ps
module fixed_speed_monitor #(
    parameter int DIN_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    input wire logic [DIN_W-1:0] din,
    input wire logic [15:0] ctrl_word,
    input wire logic [31:0] external_setpoint,
    input wire logic [31:0] effective_fixed_speed,
    input wire logic fixed_speed_selected_flag,
    input wire logic [31:0] speed_setpoint
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic tk;
    logic [3:0] bus_q;
    logic [2:0] quiet_q;
    assign tk = hsel && htrans[1];
    // quiet_q counts edges since any cause an output may follow
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_q <= 4'h0;
            quiet_q <= 3'h0;
        end else begin
            bus_q <= {bus_q[2:0], tk};
            if (tk || $changed(din) || $changed(ctrl_word) || $changed(external_setpoint))
                quiet_q <= 3'h0;
            else if (quiet_q != 3'h7)
                quiet_q <= quiet_q + 3'h1;
        end
    end
    property p_rst_zero;
        disable iff (1'b0) !hresetn |->
            effective_fixed_speed == 32'h0 && !fixed_speed_selected_flag && speed_setpoint == 32'h0;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("outputs not clear in reset");
    property p_flag;
        effective_fixed_speed != 32'h0 |-> fixed_speed_selected_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("result without flag");
    property p_none_zero;
        !fixed_speed_selected_flag |-> effective_fixed_speed == 32'h0;
    endproperty
    a_none_zero: assert property (p_none_zero) else $error("nonzero result unselected");
    property p_stable;
        quiet_q >= 3'h3 |-> $stable(effective_fixed_speed) && $stable(speed_setpoint)
            && $stable(fixed_speed_selected_flag);
    endproperty
    a_stable: assert property (p_stable) else $error("output moved without cause");
    property p_cause;
        $changed(effective_fixed_speed) && bus_q == 4'h0 |->
            $past(din, 3) != $past(din, 4) || $past(ctrl_word, 3) != $past(ctrl_word, 4);
    endproperty
    a_cause: assert property (p_cause) else $error("result change off input timing");
    property p_rd_eff;
        tk && !hwrite && haddr == 12'h060 |=> hrdata == $past(effective_fixed_speed);
    endproperty
    a_rd_eff: assert property (p_rd_eff) else $error("result readback wrong");
    property p_rd_state;
        tk && !hwrite && haddr == 12'h064 |=> hrdata == {31'h0, $past(fixed_speed_selected_flag)};
    endproperty
    a_rd_state: assert property (p_rd_state) else $error("status readback wrong");
    property p_rd_sp;
        tk && !hwrite && haddr == 12'h070 |=> hrdata == $past(speed_setpoint);
    endproperty
    a_rd_sp: assert property (p_rd_sp) else $error("setpoint readback wrong");
    c_sel: cover property ($rose(fixed_speed_selected_flag));
    c_neg: cover property (speed_setpoint[31]);
    c_rd: cover property (tk && !hwrite && haddr == 12'h060);
endmodule // fixed_speed_monitor
bind fixed_speed_select fixed_speed_monitor #(.DIN_W(DIN_W)) mon (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hrdata, .din, .ctrl_word, .external_setpoint, .effective_fixed_speed,
    .fixed_speed_selected_flag, .speed_setpoint);

//--- tb/select_source_model.sv
/* far side: digital inputs and control word of the controller.
   assumes levels change just after a rising edge. */
`timescale 1ns/100ps
module select_source_model (
    input wire logic hclk,
    input wire logic [3:0] sel,
    input wire logic inv,
    output logic [7:0] din,
    output logic [15:0] ctrl_word
);
    initial begin
        din = 8'hA0;
        ctrl_word = 16'h0000;
    end
    always @(posedge hclk) begin
        din <= {4'hA, sel}; // upper inputs unrouted, driven 4'hA to catch stray routing
        ctrl_word <= {4'h0, inv, 11'h000};
    end
endmodule // select_source_model

//--- tb/fixed_speed_select_tb.sv
/* bench for the fixed speed selector over ahb-lite.
   assumes the monitor binds itself; the source model drives din. */
`timescale 1ns/100ps
module fixed_speed_select_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, flag, inv;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, ext, eff, sp, rd, exp_v;
    logic [7:0] din;
    logic [15:0] ctrl_word;
    logic [3:0] sel;
    int err_count, checked, cyc;
    fixed_speed_select dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .din, .ctrl_word, .external_setpoint(ext),
        .effective_fixed_speed(eff), .fixed_speed_selected_flag(flag), .speed_setpoint(sp));
    select_source_model model (.hclk, .sel, .inv, .din, .ctrl_word);
    function automatic logic [31:0] v(input int n);
        return (n == 4) ? 32'hFFFFFF00 : 32'h111 * n;
    endfunction
    task automatic conclude();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic pick(input int s);
        sel <= s[3:0];
        repeat (5) @(posedge hclk);
        chk({31'h0, flag}, {31'h0, s != 0});
        chk(eff, exp_v);
    endtask
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        hresetn <= 1'b0; // nba so the async reset edge is not lost at time zero
        {hsel, hwrite, inv} = 3'h0;
        {haddr, htrans, hwdata, sel} = '0;
        ext = 32'h00000500;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int n = 1; n <= 15; n++) rchk(12'(4 * (n - 1)), 32'h0);
        rchk(12'h040, 32'h1);
        for (int k = 0; k < 4; k++) rchk(12'h050 + 12'(4 * k), 32'h0);
        rchk(12'h060, 32'h0);
        for (int n = 1; n <= 15; n++) bus(1'b1, 12'(4 * (n - 1)), v(n));
        for (int n = 1; n <= 15; n++) rchk(12'(4 * (n - 1)), v(n));
        for (int k = 0; k < 4; k++) bus(1'b1, 12'h050 + 12'(4 * k), 32'h100 | k);
        bus(1'b1, 12'h06C, 32'h1);
        for (int s = 0; s < 16; s++) begin
            exp_v = 32'h0;
            for (int k = 0; k < 4; k++) if (s[k]) exp_v += v(k + 1);
            pick(s);
            chk(sp, exp_v);
        end
        bus(1'b1, 12'h040, 32'h2);
        for (int s = 0; s < 16; s++) begin
            exp_v = (s == 0) ? 32'h0 : v(s);
            pick(s);
        end
        rchk(12'h064, 32'h1);
        bus(1'b1, 12'h068, 32'h0000020B);
        inv <= 1'b1;
        repeat (5) @(posedge hclk);
        chk(sp, -v(15));
        rchk(12'h070, -v(15));
        bus(1'b1, 12'h06C, 32'h0);
        repeat (3) @(posedge hclk);
        chk(sp, -ext);
        inv <= 1'b0;
        repeat (5) @(posedge hclk);
        chk(sp, ext);
        bus(1'b1, 12'h0FC, 32'h12345678);
        rchk(12'h0FC, 32'h0);
        // second reset mid-run: settings must return to factory values
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(12'h040, 32'h1);
        rchk(12'h038, 32'h0);
        rchk(12'h05C, 32'h0);
        chk(eff, 32'h0);
        // constant-one source: selected with a zero value still raises the flag
        bus(1'b1, 12'h050, 32'h00000001);
        repeat (3) @(posedge hclk);
        chk({31'h0, flag}, 32'h1);
        chk(eff, 32'h0);
        conclude();
    end
endmodule // fixed_speed_select_tb
